// ===== src/serial_adc_pkg.sv
/*
 * Shared constants, state type and channel decoder for the serial converter interface.
 * Assumes a single 20 MHz system clock; all link timing is counted in its cycles.
 */
package serial_adc_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int DESELECT_NS = 250;
    localparam int DESELECT_RAW = (DESELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DESELECT_CYC = (DESELECT_RAW < 1) ? 1 : DESELECT_RAW;
    localparam int DESEL_W = 8;

    // ------------------------------------------------------------------
    // Widths and bit positions
    // ------------------------------------------------------------------
    localparam int RESULT_W = 8;
    localparam int CNT_W = 4;
    localparam int ADDR_W = 4;
    localparam logic [CNT_W-1:0] LAST_BIT = 4'h7;
    localparam logic [CNT_W-1:0] LSB_DONE = 4'h8;
    localparam logic [CNT_W-1:0] FIRST_LSB_NEXT = 4'h1;
    localparam logic [RESULT_W-1:0] SAR_FIRST_TRIAL = 8'h80;

    // Index of each pin inside the synchroniser vector.
    localparam int SYNC_W = 5;
    localparam int PIN_SCLK = 0;
    localparam int PIN_SEL_N = 1;
    localparam int PIN_DIN = 2;
    localparam int PIN_SHIFT_EN_N = 3;
    localparam int PIN_CMP = 4;

    // Channel codes for the fixed single-pair variant and the common input.
    localparam logic [2:0] FIXED_POS = 3'h0;
    localparam logic [2:0] FIXED_NEG = 3'h1;
    localparam logic [2:0] COM_NEG = 3'h0;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        WAIT_START,
        SHIFT_ADDR,
        SETTLE,
        CONVERT,
        FINISH,
        LSB_OUT,
        HOLD_LOW
    } state_t;

    // Length of the channel assignment word for a given channel count.
    function automatic int addr_bits(input int n_chan);
        case (n_chan)
            2: return 2;
            4: return 3;
            8: return 4;
            default: return 0;
        endcase
    endfunction : addr_bits

    // Returns {single_ended, positive channel, negative channel}.
    function automatic logic [6:0] mux_decode(input logic [ADDR_W-1:0] a, input int ab);
        logic single;
        logic odd;
        logic [1:0] sel;
        logic [2:0] pos;
        logic [2:0] neg;
        single = 1'b0;
        odd = 1'b0;
        sel = 2'h0;
        pos = FIXED_POS;
        neg = FIXED_NEG;
        if (ab >= 2)
        begin
            single = a[ab-1];
            odd = a[ab-2];
            if (ab == 4)
            begin
                sel = a[1:0];
            end
            else if (ab == 3)
            begin
                sel = {1'b0, a[0]};
            end
            pos = {sel, odd};
            neg = single ? COM_NEG : {sel, ~odd};
        end
        return {single, pos, neg};
    endfunction : mux_decode

endpackage : serial_adc_pkg

// ===== src/pin_sync.sv
/*
 * Two-flop synchroniser with edge pulses for a vector of asynchronous pins.
 * Assumes every bit is unrelated to mclk_i; edges are one-cycle pulses on mclk_i.
 */
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o,
    output logic [WIDTH-1:0] rise_o,
    output logic [WIDTH-1:0] fall_o
);

    localparam int WARM_W = 3;

    // Edges stay masked until the history flop holds a real sample, so the reset
    // value can never pose as an edge on a pin that idles high.
    logic [WARM_W-1:0] warm_q;

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            warm_q <= '0;
        end
        else
        begin
            warm_q <= {warm_q[WARM_W-2:0], 1'b1};
        end
    end

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : gen_bit
            logic meta_q;
            logic sync_q;
            logic prev_q;

            always_ff @(posedge mclk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                    prev_q <= 1'b0;
                end
                else
                begin
                    meta_q <= pin_i[g];
                    sync_q <= meta_q;
                    prev_q <= sync_q;
                end
            end

            assign level_o[g] = sync_q;
            assign rise_o[g] = sync_q & ~prev_q & warm_q[WARM_W-1];
            assign fall_o[g] = ~sync_q & prev_q & warm_q[WARM_W-1];
        end
    endgenerate

endmodule : pin_sync

// ===== src/sar_core.sv
/*
 * Successive-approximation register and the output shift register it loads.
 * Assumes the comparator input is already synchronised and settled for the trial code.
 */
`timescale 1ns/100ps
module sar_core
    import serial_adc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic clear_i,
    input wire logic start_i,
    input wire logic decide_i,
    input wire logic [CNT_W-1:0] bit_idx_i,
    input wire logic cmp_i,
    input wire logic load_i,
    output logic [RESULT_W-1:0] trial_o,
    output logic [RESULT_W-1:0] shift_o
);

    logic [RESULT_W-1:0] trial_q;
    logic [RESULT_W-1:0] shift_q;
    logic [2:0] pos;

    assign pos = 3'(LAST_BIT - bit_idx_i);

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            trial_q <= '0;
        end
        else if (clear_i || start_i)
        begin
            trial_q <= clear_i ? '0 : SAR_FIRST_TRIAL;
        end
        else if (decide_i)
        begin
            // A low comparator clears the trial bit to zero, so a reversed input pair ends as all zeros.
            trial_q[pos] <= cmp_i;
            if (pos != 3'h0)
            begin
                trial_q[pos - 3'h1] <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            shift_q <= '0;
        end
        else if (clear_i)
        begin
            shift_q <= '0;
        end
        else if (load_i)
        begin
            shift_q <= trial_q;
        end
    end

    assign trial_o = trial_q;
    assign shift_o = shift_q;

endmodule : sar_core

// ===== src/serial_adc_if.sv
/*
 * Serial control and data interface of an 8-bit successive-approximation converter with input multiplexer.
 * Assumes the link clock, select, data-in, shift-enable and comparator arrive asynchronously to mclk_i.
 */
`timescale 1ns/100ps
module serial_adc_if
    import serial_adc_pkg::*;
#(
    parameter int N_CHAN = 8
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic sclk_i,
    input wire logic select_n_i,
    input wire logic serial_in_i,
    input wire logic shift_en_n_i,
    input wire logic cmp_i,
    output logic serial_out_o,
    output logic serial_out_oe_o,
    output logic conv_status_o,
    output logic [RESULT_W-1:0] dac_code_o,
    output logic single_end_o,
    output logic [2:0] pos_chan_o,
    output logic [2:0] neg_chan_o
);

    localparam int AB = addr_bits(N_CHAN);
    localparam bit HAS_SHIFT_EN = (N_CHAN == 8);
    localparam bit ONE_CHAN = (N_CHAN == 1);
    localparam logic [CNT_W-1:0] ADDR_LAST = CNT_W'((AB > 0) ? AB - 1 : 0);
    localparam logic [DESEL_W-1:0] DESEL_MAX = DESEL_W'(DESELECT_CYC);

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    logic [SYNC_W-1:0] pins;
    logic [SYNC_W-1:0] lvl;
    logic [SYNC_W-1:0] rise;
    logic [SYNC_W-1:0] fall;

    assign pins = {cmp_i, shift_en_n_i, serial_in_i, select_n_i, sclk_i};

    pin_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .pin_i(pins),
        .level_o(lvl),
        .rise_o(rise),
        .fall_o(fall)
    );

    logic sel_n;
    logic din;
    logic cmp;
    logic shift_en_n;
    logic clk_rise;
    logic clk_fall;

    assign sel_n = lvl[PIN_SEL_N];
    assign din = lvl[PIN_DIN];
    assign cmp = lvl[PIN_CMP];
    assign shift_en_n = lvl[PIN_SHIFT_EN_N];
    // Link edges only count while selected.
    assign clk_rise = rise[PIN_SCLK] & ~sel_n;
    assign clk_fall = fall[PIN_SCLK] & ~sel_n;

    // ------------------------------------------------------------------
    // Deselect clear
    // ------------------------------------------------------------------
    logic [DESEL_W-1:0] desel_q;
    logic clear;

    // Clock and select both high for the deselect time clears everything except the channel selection outputs.
    assign clear = sel_n && (desel_q == DESEL_MAX);

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            desel_q <= '0;
        end
        else if (!(sel_n && lvl[PIN_SCLK]))
        begin
            desel_q <= '0;
        end
        else if (desel_q != DESEL_MAX)
        begin
            desel_q <= desel_q + DESEL_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    state_t st_q;
    logic [CNT_W-1:0] cnt_q;
    logic [ADDR_W-1:0] addr_q;
    logic [RESULT_W-1:0] shift_bits;
    logic lsb_step;

    assign lsb_step = clk_fall && (!HAS_SHIFT_EN || !shift_en_n);

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st_q <= WAIT_START;
            cnt_q <= '0;
        end
        else if (clear)
        begin
            st_q <= WAIT_START;
            cnt_q <= '0;
        end
        else
        begin
            case (st_q)
                WAIT_START:
                begin
                    if (clk_rise && din)
                    begin
                        st_q <= ONE_CHAN ? SETTLE : SHIFT_ADDR;
                        cnt_q <= '0;
                    end
                end
                SHIFT_ADDR:
                begin
                    if (clk_rise)
                    begin
                        cnt_q <= cnt_q + CNT_W'(1);
                        if (cnt_q == ADDR_LAST)
                        begin
                            st_q <= SETTLE;
                        end
                    end
                end
                SETTLE:
                begin
                    if (clk_fall)
                    begin
                        st_q <= CONVERT;
                        cnt_q <= '0;
                    end
                end
                CONVERT:
                begin
                    if (clk_fall)
                    begin
                        cnt_q <= cnt_q + CNT_W'(1);
                        if (cnt_q == LAST_BIT)
                        begin
                            st_q <= FINISH;
                        end
                    end
                end
                FINISH:
                begin
                    if (clk_rise)
                    begin
                        st_q <= LSB_OUT;
                        // The single-channel part skips straight to the low tail.
                        cnt_q <= ONE_CHAN ? LSB_DONE : FIRST_LSB_NEXT;
                    end
                end
                LSB_OUT:
                begin
                    if (lsb_step)
                    begin
                        if (cnt_q == LSB_DONE)
                        begin
                            st_q <= HOLD_LOW;
                        end
                        else
                        begin
                            cnt_q <= cnt_q + CNT_W'(1);
                        end
                    end
                end
                HOLD_LOW:
                begin
                    st_q <= HOLD_LOW;
                end
                default:
                begin
                    st_q <= WAIT_START;
                end
            endcase
        end
    end

    // Address register only moves while addressing; data in is ignored afterwards.
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            addr_q <= '0;
        end
        else if (clear || (st_q == WAIT_START))
        begin
            addr_q <= '0;
        end
        else if ((st_q == SHIFT_ADDR) && clk_rise)
        begin
            addr_q <= {addr_q[ADDR_W-2:0], din};
        end
    end

    // ------------------------------------------------------------------
    // Channel selection
    // ------------------------------------------------------------------
    logic [6:0] mux;

    assign mux = mux_decode(addr_q, AB);

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            single_end_o <= 1'b0;
            pos_chan_o <= FIXED_POS;
            neg_chan_o <= FIXED_NEG;
        end
        else if ((st_q == SETTLE) && clk_fall && !clear)
        begin
            // Fresh setup every conversion: single-ended or adjacent pair.
            single_end_o <= mux[6];
            pos_chan_o <= mux[5:3];
            neg_chan_o <= mux[2:0];
        end
    end

    // ------------------------------------------------------------------
    // Approximation and output shift registers
    // ------------------------------------------------------------------
    sar_core u_sar (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .clear_i(clear),
        .start_i((st_q == SETTLE) && clk_fall),
        .decide_i((st_q == CONVERT) && clk_fall),
        .bit_idx_i(cnt_q),
        .cmp_i(cmp),
        .load_i((st_q == FINISH) && clk_rise),
        .trial_o(dac_code_o),
        .shift_o(shift_bits)
    );

    // ------------------------------------------------------------------
    // Serial output and status
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            conv_status_o <= 1'b0;
        end
        else if (clear)
        begin
            conv_status_o <= 1'b0;
        end
        else if ((st_q == SETTLE) && clk_fall)
        begin
            conv_status_o <= 1'b1;
        end
        else if ((st_q == FINISH) && clk_rise)
        begin
            conv_status_o <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            serial_out_o <= 1'b0;
            serial_out_oe_o <= 1'b0;
        end
        else if (sel_n || clear)
        begin
            serial_out_o <= 1'b0;
            serial_out_oe_o <= 1'b0;
        end
        else if ((st_q == SETTLE) && clk_fall)
        begin
            serial_out_o <= 1'b0;
            serial_out_oe_o <= 1'b1;
        end
        else if ((st_q == CONVERT) && clk_fall)
        begin
            serial_out_o <= cmp;
        end
        else if ((st_q == LSB_OUT) && lsb_step)
        begin
            serial_out_o <= (cnt_q == LSB_DONE) ? 1'b0 : shift_bits[cnt_q[2:0]];
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    start_wait_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (st_q == WAIT_START && clk_rise && !din && !clear) |=> (st_q == WAIT_START))
        else $error("Zero on data in left the start wait.");

    addr_frozen_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (st_q == CONVERT && !clear) |=> $stable(addr_q) && $stable(pos_chan_o))
        else $error("Address changed during conversion.");

    status_rise_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (st_q == SETTLE && clk_fall && !clear) |=> conv_status_o && serial_out_oe_o && (st_q == CONVERT))
        else $error("Settling did not raise status and output enable.");

    lead_zero_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        $rose(serial_out_oe_o) |-> !serial_out_o && conv_status_o)
        else $error("Output enabled without a leading zero.");

    msb_bit_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (st_q == CONVERT && clk_fall && !sel_n && !clear) |=> (serial_out_o == $past(cmp)))
        else $error("Decided bit not driven on data out.");

    status_fall_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (st_q == FINISH && clk_rise && !clear) |=> !conv_status_o ##0 (dac_code_o == $past(dac_code_o)))
        else $error("Status did not drop at the end of conversion.");

    shift_hold_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (HAS_SHIFT_EN && st_q == LSB_OUT && shift_en_n && !sel_n && !clear) |=> $stable(serial_out_o))
        else $error("Data out moved while shift enable was high.");

    low_tail_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (st_q == HOLD_LOW && !sel_n) [*2] |-> !serial_out_o && serial_out_oe_o)
        else $error("Data out not held low after output.");

    release_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        sel_n |=> !serial_out_oe_o)
        else $error("Data out driven while deselected.");

    clear_all_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        clear |=> (st_q == WAIT_START) && !conv_status_o && (dac_code_o == '0) && (addr_q == '0))
        else $error("Deselect did not clear the registers.");

endmodule : serial_adc_if

// ===== test/host_model.sv
/*
 * Host side of the serial converter link: makes the link clock, select and data in, and records data out.
 * Assumes it is stepped on falling edges of mclk_i and that 8 mclk cycles make one link clock period.
 */
`timescale 1ns/100ps
module host_model (
    input wire logic mclk_i,
    input wire logic sdo_i,
    input wire logic sdo1_i,
    input wire logic oe_i,
    input wire logic status_i,
    input wire logic [6:0] mux_i,
    output logic sclk_o,
    output logic select_n_o,
    output logic serial_in_o
);
    logic [23:0] out_v;
    logic [23:0] out1_v;
    logic [23:0] oe_v;
    logic [23:0] st_v;
    logic [6:0] mux_s;

    initial
    begin
        sclk_o = 1'b1;
        select_n_o = 1'b1;
        serial_in_o = 1'b0;
    end

    // ------------------------------------------------------------------
    // One sequence: z leading zeros, then nper periods from the start bit on (start bit, address, rest)
    // ------------------------------------------------------------------
    task automatic xfer(input int z, input logic [3:0] addr, input int nper);
        int p;
        select_n_o = 1'b0;
        repeat (4) @(negedge mclk_i);
        for (int i = 0; i < z + nper; i++)
        begin
            p = i - z;
            @(negedge mclk_i);
            sclk_o = 1'b0;
            if (p < 0)
                serial_in_o = 1'b0;
            else if (p == 0)
                serial_in_o = 1'b1;
            else if (p <= 4)
                serial_in_o = addr[4-p];
            else
                serial_in_o = ~serial_in_o;
            repeat (4) @(negedge mclk_i);
            sclk_o = 1'b1;
            repeat (3) @(negedge mclk_i);
            if (p >= 0)
            begin
                out_v[p] = sdo_i;
                out1_v[p] = sdo1_i;
                oe_v[p] = oe_i;
                st_v[p] = status_i;
            end
            if (p == 20)
                mux_s = mux_i;
        end
        repeat (4) @(negedge mclk_i);
        select_n_o = 1'b1;
        repeat (8) @(negedge mclk_i);
    endtask : xfer
endmodule : host_model

// ===== test/tb_top.sv
/*
 * Self-checking bench for the serial converter interface, eight-channel and single-channel variants side by side.
 * Assumes a 20 MHz mclk and a behavioural comparator that follows each trial code.
 */
`timescale 1ns/100ps
module tb_top
    import serial_adc_pkg::*;
;
    logic mclk, nrst_n, sclk, sel_n, sdi, shift_en_n, cmp, cmp1, so, oe, st, st1, single_end, so1, oe1;
    logic [RESULT_W-1:0] dac, dac1, vin, vin1, e, e1;
    logic [2:0] pos, neg, pos1, neg1;
    logic [3:0] a;
    logic [31:0] seed, r;
    wire sdo_w = oe ? so : 1'bz;
    wire sdo1_w = oe1 ? so1 : 1'bz;
    int n_fail, comparisons;

    serial_adc_if #(.N_CHAN(8)) dut (.mclk_i(mclk), .nrst_i(nrst_n), .sclk_i(sclk), .select_n_i(sel_n),
        .serial_in_i(sdi), .shift_en_n_i(shift_en_n), .cmp_i(cmp), .serial_out_o(so), .serial_out_oe_o(oe),
        .conv_status_o(st), .dac_code_o(dac), .single_end_o(single_end), .pos_chan_o(pos), .neg_chan_o(neg));
    serial_adc_if #(.N_CHAN(1)) dut_single (.mclk_i(mclk), .nrst_i(nrst_n), .sclk_i(sclk), .select_n_i(sel_n),
        .serial_in_i(sdi), .shift_en_n_i(shift_en_n), .cmp_i(cmp1), .serial_out_o(so1), .serial_out_oe_o(oe1),
        .conv_status_o(st1), .dac_code_o(dac1), .single_end_o(), .pos_chan_o(pos1), .neg_chan_o(neg1));
    host_model host (.mclk_i(mclk), .sdo_i(sdo_w), .sdo1_i(sdo1_w), .oe_i(oe), .status_i(st),
        .mux_i({single_end, pos, neg}), .sclk_o(sclk), .select_n_o(sel_n), .serial_in_o(sdi));

    // ------------------------------------------------------------------
    // Clock, comparator and helpers
    // ------------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    always @(negedge mclk)
    begin
        cmp <= vin > dac;
        cmp1 <= vin1 > dac1;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    function automatic logic [7:0] sar(input logic [7:0] v);
        logic [7:0] q;
        q = 8'h00;
        for (int i = 7; i >= 0; i--)
            if (v > (q | (8'h01 << i)))
                q = q | (8'h01 << i);
        return q;
    endfunction : sar

    function automatic logic [7:0] mux_exp(input logic [3:0] x);
        return {1'b0, x[3], x[1:0], x[2], x[3] ? 3'h0 : {x[1:0], ~x[2]}};
    endfunction : mux_exp

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        nrst_n = 1'b0;
        vin = 8'h00;
        vin1 = 8'h00;
        shift_en_n = 1'b0;
        seed = 32'h0000_003c;
        n_fail = 0;
        comparisons = 0;
        repeat (6) @(negedge mclk);
        nrst_n = 1'b1;
        repeat (6) @(negedge mclk);
        check(dac, 8'h00);
        for (int k = 0; k < 18; k++)
        begin
            a = (k == 17) ? 4'h1 : k[3:0];
            r = xs();
            vin = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : r[7:0];
            vin1 = r[15:8];
            shift_en_n = (k % 3 == 2);
            e = sar(vin);
            e1 = sar(vin1);
            host.xfer(int'(r[17:16]), a, (k == 16) ? 8 : 24);
            if (k == 16)
            begin
                check(dac, 8'h00);
                check(oe, 8'h00);
                check(st, 8'h00);
                check(dac1, 8'h00);
                check(st1, 8'h00);
                check(oe1, 8'h00);
                continue;
            end
            for (int p = 0; p < 5; p++)
                check(host.oe_v[p], 8'h00);
            check(host.st_v[4], 8'h00);
            check(host.st_v[5], 8'h01);
            check(host.st_v[12], 8'h01);
            check(host.st_v[14], 8'h00);
            check({host.oe_v[5], host.out_v[5]}, 8'h02);
            for (int p = 0; p < 8; p++)
                check(host.out_v[6+p], e[7-p]);
            for (int p = 1; p < 8; p++)
                check(host.out_v[13+p], shift_en_n ? e[0] : e[p]);
            check(host.out_v[21], shift_en_n ? e[0] : 1'b0);
            check({host.oe_v[23], host.out_v[23]}, {6'h00, 1'b1, shift_en_n & e[0]});
            check(host.mux_s, mux_exp(a));
            check(host.out1_v[1], 8'h00);
            for (int p = 0; p < 8; p++)
                check(host.out1_v[2+p], e1[7-p]);
            for (int p = 10; p < 24; p++)
                check(host.out1_v[p], 8'h00);
            check({pos1, neg1}, {FIXED_POS, FIXED_NEG});
        end
        summarize();
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        summarize();
    end
endmodule : tb_top
